// file: logic/sto_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts of the torque cutoff block
// Assumes: 40 MHz control clock, AXI4-Lite register access with 32-bit data
// Notes:   Counts derive from times printed in their own units
`ifndef CUTOFF_DEFINES_SVH
`define CUTOFF_DEFINES_SVH

`define CLK_FREQ_KHZ        40000
`define OFF_FILTER_TIME_US  1000
`define OFF_FILTER_CYCLES   (`OFF_FILTER_TIME_US * `CLK_FREQ_KHZ / 1000)
`define MS_TICK_TIME_US     1000
`define MS_TICK_CYCLES      (`MS_TICK_TIME_US * `CLK_FREQ_KHZ / 1000)

`define OFS_CONTROL         8'h00
`define OFS_STATUS          8'h04
`define OFS_STOP_SELECT     8'h08
`define OFS_BRAKE_DELAY     8'h0C
`define OFS_RELEASE_SPEED   8'h10
`define OFS_DIRECTION       8'h14
`define OFS_CONTROL_MODE    8'h18
`define OFS_ACTIVE          8'h1C

`define CTRL_SERVO_ON       0
`define CTRL_ALARM_RESET    1
`define CTRL_CONFIG         2
`define SEL_ALARM_STOP      0
`define SEL_SERVO_OFF_STOP  1

`define RST_STOP_SEL        1'h0
`define RST_BRAKE_DELAY     16'h0032
`define RST_RELEASE_SPEED   16'h001E
`define RST_DIRECTION       1'h1
`define RST_CONTROL_MODE    3'h0
`define CONTROL_MODE_MAX    3'h6
`define FATAL_CODE          16'h0990

`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// file: logic/sto_pkg.sv
// Purpose: Types shared by the torque cutoff block
// Assumes: Nothing beyond the defines header
// Notes:   State codes are fixed so status reads are stable
package cutoff_pkg;

	typedef enum logic [1:0] {
		st_run    = 2'b00,
		st_cutoff = 2'b01,
		st_fatal  = 2'b10
	} cutoff_state_t;

endpackage

// file: logic/safety_input_filter.sv
// Purpose: Synchronise one safety pin and suppress short off pulses
// Assumes: Pin is asynchronous to aclk; high means on
// Notes:   Off must last longer than OFF_CYCLES before it is reported
`timescale 1ns/1ps
`default_nettype none

module safety_input_filter #(
	parameter int unsigned OFF_CYCLES = 40000
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic pin_in,
	output logic      level_on
);

	localparam int unsigned CW = $clog2(OFF_CYCLES + 1);

	logic          sync1;
	logic          sync2;
	logic          sync3;
	logic [CW-1:0] off_count;

	// Reset to on so a fresh boot does not raise a cutoff before the pins are seen
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1 <= 1'b1;
			sync2 <= 1'b1;
			sync3 <= 1'b1;
		end else begin
			sync1 <= pin_in;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level_on  <= 1'b1;
			off_count <= '0;
		end else if (sync2 == sync3) begin
			if (sync3) begin
				level_on  <= 1'b1;
				off_count <= '0;
			end else if (off_count == OFF_CYCLES[CW-1:0]) begin
				level_on <= 1'b0;
			end else begin
				off_count <= off_count + 1'b1;
			end
		end
	end

endmodule // safety_input_filter

`default_nettype wire

// file: logic/safe_torque_off_monitor.sv
// Purpose: Torque cutoff path of a servo drive with monitor, alarm and brake sequencing
// Assumes: 40 MHz aclk, AXI4-Lite register access, motor speed and command on aclk
// Notes:   Parameter store is kept across aresetn; aresetn stands for a power cycle
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sto_defines.svh"

module safe_torque_off_monitor
	import cutoff_pkg::*;
#(
	parameter int unsigned OFF_FILTER_CYCLES = `OFF_FILTER_CYCLES,
	parameter int unsigned MS_TICK_CYCLES    = `MS_TICK_CYCLES
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        param_store_clear_n,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        safety_input_one,
	input  wire logic        safety_input_two,
	input  wire logic [15:0] motor_speed,
	input  wire logic        cmd_forward,
	output logic             cutoff_monitor_output,
	output logic             torque_enable,
	output logic             alarm_output,
	output logic             dynamic_brake_engaged,
	output logic             brake_hold_output,
	output logic             servo_ready,
	output logic             motor_turn_ccw,
	output logic [2:0]       control_mode
);

	function automatic logic is_mapped(input logic [7:0] addr);
		return addr[1:0] == 2'h0 && addr <= `OFS_ACTIVE;
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] new_v,
	                                        input logic [3:0] strb);
		return {strb[1] ? new_v[15:8] : old_v[15:8], strb[0] ? new_v[7:0] : old_v[7:0]};
	endfunction

	logic [1:0]  safety_on;
	cutoff_state_t state;
	logic [7:0]  aw_addr;
	logic        aw_held;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        w_held;
	logic        next_aw_held;
	logic        next_w_held;
	logic        next_rvalid;
	logic        do_write;
	logic        wr_lo;
	logic        servo_on;
	logic        alarm_reset_pulse;
	logic        config_pulse;
	logic        alarm_stop_selection;
	logic        servo_off_stop_selection;
	logic [15:0] running_brake_delay;
	logic [15:0] brake_release_speed;
	logic        direction_switch_setting;
	logic [2:0]  control_mode_selection;
	logic        booted;
	logic [15:0] active_brake_delay;
	logic [15:0] active_release_speed;
	logic        active_direction;
	logic        idle;
	logic [$clog2(MS_TICK_CYCLES+1)-1:0] ms_count;
	logic [15:0] brake_ms;
	logic        brake_due;
	logic [31:0] read_value;

	// One filter per safety input; nothing reads the raw pins past here
	for (genvar i = 0; i < 2; i++) begin : g_safety
		safety_input_filter #(
			.OFF_CYCLES(OFF_FILTER_CYCLES)
		) u_filter (
			.aclk    (aclk),
			.aresetn (aresetn),
			.pin_in  (i == 0 ? safety_input_one : safety_input_two),
			.level_on(safety_on[i])
		);
	end

	// AXI4-Lite write side: address and data are taken in either order
	assign do_write     = aw_held && w_held && !bvalid;
	assign next_aw_held = (aw_held && !do_write) || (awvalid && awready);
	assign next_w_held  = (w_held && !do_write) || (wvalid && wready);
	assign wr_lo        = do_write && is_mapped(aw_addr);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			awready <= 1'b0;
			aw_addr <= 8'h00;
		end else begin
			aw_held <= next_aw_held;
			awready <= !next_aw_held;
			if (awvalid && awready) begin
				aw_addr <= awaddr;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			wready <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			w_held <= next_w_held;
			wready <= !next_w_held;
			if (wvalid && wready) begin
				w_data <= wdata;
				w_strb <= wstrb;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= `RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp  <= is_mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// Control register: servo-on level plus self-clearing command pulses
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			servo_on          <= 1'b0;
			alarm_reset_pulse <= 1'b0;
			config_pulse      <= 1'b0;
		end else begin
			alarm_reset_pulse <= 1'b0;
			config_pulse      <= 1'b0;
			if (wr_lo && aw_addr == `OFS_CONTROL && w_strb[0]) begin
				servo_on          <= w_data[`CTRL_SERVO_ON];
				alarm_reset_pulse <= w_data[`CTRL_ALARM_RESET];
				config_pulse      <= w_data[`CTRL_CONFIG];
			end
		end
	end

	// Always-enabled class: used straight from the written value in every state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alarm_stop_selection     <= `RST_STOP_SEL;
			servo_off_stop_selection <= `RST_STOP_SEL;
		end else if (wr_lo && aw_addr == `OFS_STOP_SELECT && w_strb[0]) begin
			alarm_stop_selection     <= w_data[`SEL_ALARM_STOP];
			servo_off_stop_selection <= w_data[`SEL_SERVO_OFF_STOP];
		end
	end

	// Parameter store survives aresetn like non-volatile memory; only its own clear wipes it
	always_ff @(posedge aclk) begin
		if (!param_store_clear_n) begin
			running_brake_delay      <= `RST_BRAKE_DELAY;
			brake_release_speed      <= `RST_RELEASE_SPEED;
			direction_switch_setting <= `RST_DIRECTION;
			control_mode_selection   <= `RST_CONTROL_MODE;
		end else if (wr_lo) begin
			if (aw_addr == `OFS_BRAKE_DELAY) begin
				running_brake_delay <= merge16(running_brake_delay, w_data, w_strb);
			end
			if (aw_addr == `OFS_RELEASE_SPEED) begin
				brake_release_speed <= merge16(brake_release_speed, w_data, w_strb);
			end
			if (aw_addr == `OFS_DIRECTION && w_strb[0]) begin
				direction_switch_setting <= w_data[0];
			end
			// Out-of-range modes are dropped rather than stored
			if (aw_addr == `OFS_CONTROL_MODE && w_strb[0] && w_data[2:0] <= `CONTROL_MODE_MAX) begin
				control_mode_selection <= w_data[2:0];
			end
		end
	end

	// Active copies: booted marks the first cycle after a power reset
	assign idle = motor_speed == 16'h0000 && !servo_on;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			booted               <= 1'b0;
			active_brake_delay   <= `RST_BRAKE_DELAY;
			active_release_speed <= `RST_RELEASE_SPEED;
			active_direction     <= `RST_DIRECTION;
			control_mode         <= `RST_CONTROL_MODE;
		end else begin
			booted <= 1'b1;
			if (!booted || idle) begin
				active_brake_delay   <= running_brake_delay;
				active_release_speed <= brake_release_speed;
			end
			if (!booted || config_pulse) begin
				active_direction <= direction_switch_setting;
			end
			if (!booted) begin
				control_mode <= control_mode_selection;
			end
		end
	end

	// Cutoff sequencing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= st_run;
		end else begin
			unique case (state)
				st_run: begin
					if (!safety_on[0] || !safety_on[1]) begin
						state <= st_cutoff;
					end
				end
				st_cutoff: begin
					if (alarm_reset_pulse) begin
						if (safety_on == 2'b11) begin
							state <= st_run;
						end else if (safety_on != 2'b00) begin
							state <= st_fatal;
						end
						// Both still off: alarm stays raised
					end
				end
				st_fatal: begin
					state <= st_fatal;
				end
				default: begin
					state <= st_cutoff;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cutoff_monitor_output <= 1'b0;
			torque_enable         <= 1'b0;
			alarm_output          <= 1'b0;
			servo_ready           <= 1'b0;
			dynamic_brake_engaged <= 1'b1;
			motor_turn_ccw        <= 1'b0;
		end else begin
			cutoff_monitor_output <= safety_on == 2'b00;
			torque_enable         <= state == st_run && servo_on && safety_on == 2'b11;
			alarm_output          <= state != st_run;
			servo_ready           <= state == st_run && safety_on == 2'b11;
			if (state != st_run) begin
				dynamic_brake_engaged <= !alarm_stop_selection;
			end else begin
				dynamic_brake_engaged <= !servo_on && !servo_off_stop_selection;
			end
			motor_turn_ccw <= active_direction ? cmd_forward : !cmd_forward;
		end
	end

	// Running brake delay counted in milliseconds from cutoff entry
	assign brake_due = brake_ms >= active_brake_delay || motor_speed <= active_release_speed;

	always_ff @(posedge aclk) begin
		if (!aresetn || state == st_run) begin
			ms_count <= '0;
			brake_ms <= 16'h0000;
		end else if (ms_count == MS_TICK_CYCLES[$bits(ms_count)-1:0] - 1'b1) begin
			ms_count <= '0;
			if (brake_ms != 16'hFFFF) begin
				brake_ms <= brake_ms + 1'b1;
			end
		end else begin
			ms_count <= ms_count + 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			brake_hold_output <= 1'b1;
		end else if (state == st_run) begin
			brake_hold_output <= !servo_on;
		end else if (brake_due) begin
			brake_hold_output <= 1'b1;
		end
	end

	// AXI4-Lite read side
	always_comb begin
		read_value = 32'h0000_0000;
		unique case (araddr)
			`OFS_CONTROL:       read_value[`CTRL_SERVO_ON] = servo_on;
			`OFS_STATUS:        read_value = {(state == st_fatal) ? `FATAL_CODE : 16'h0000, 8'h00,
			                                  safety_on, servo_ready, dynamic_brake_engaged,
			                                  brake_hold_output, cutoff_monitor_output,
			                                  alarm_output, state != st_run};
			`OFS_STOP_SELECT:   read_value[1:0] = {servo_off_stop_selection, alarm_stop_selection};
			`OFS_BRAKE_DELAY:   read_value[15:0] = running_brake_delay;
			`OFS_RELEASE_SPEED: read_value[15:0] = brake_release_speed;
			`OFS_DIRECTION:     read_value[0] = direction_switch_setting;
			`OFS_CONTROL_MODE:  read_value[2:0] = control_mode_selection;
			`OFS_ACTIVE:        read_value[3:0] = {control_mode, active_direction};
			default:            read_value = 32'h0000_0000;
		endcase
	end

	assign next_rvalid = (rvalid && !rready) || (arvalid && arready);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid  <= 1'b0;
			arready <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= `RESP_OKAY;
		end else begin
			rvalid  <= next_rvalid;
			arready <= !next_rvalid;
			if (arvalid && arready) begin
				rdata <= is_mapped(araddr) ? read_value : 32'h0000_0000;
				rresp <= is_mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
			end
		end
	end

endmodule // safe_torque_off_monitor

`default_nettype wire

// file: verification/safety_controller_model.sv
// Purpose: Safety controller model driving both safety pins
// Assumes: Pins follow the bench request one cycle later; high means on
// Notes:   Flags a fault when the monitor disagrees with the pins for over LIMIT cycles
`timescale 1ns/1ps
`default_nettype none

module safety_controller_model #(
	parameter int unsigned LIMIT = 20
) (
	input  wire logic aclk,
	input  wire logic want_one,
	input  wire logic want_two,
	input  wire logic monitor_in,
	output logic      safety_input_one,
	output logic      safety_input_two,
	output logic      fault
);
	int unsigned lag = 0;

	initial begin
		safety_input_one = 1'b1;
		safety_input_two = 1'b1;
		fault = 1'b0;
	end

	always @(posedge aclk) begin
		safety_input_one <= want_one;
		safety_input_two <= want_two;
		// Lag allows for the filter; a monitor that never settles is a wiring or circuit fault
		lag <= ((!safety_input_one && !safety_input_two) != monitor_in) ? lag + 1 : 0;
		if (lag > LIMIT) begin
			fault <= 1'b1;
		end
	end
endmodule // safety_controller_model
`default_nettype wire

// file: verification/cutoff_properties.sv
// Purpose: Port checks of the torque cutoff block
// Assumes: Bound into safe_torque_off_monitor
// Notes:   Run counters give the input filter its margin before outputs are judged
`timescale 1ns/1ps
`default_nettype none

module cutoff_properties #(
	parameter int unsigned OFF_FILTER_CYCLES = 8
) (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        safety_input_one,
	input wire logic        safety_input_two,
	input wire logic [15:0] motor_speed,
	input wire logic        cmd_forward,
	input wire logic        cutoff_monitor_output,
	input wire logic        torque_enable,
	input wire logic        alarm_output,
	input wire logic        brake_hold_output,
	input wire logic        servo_ready,
	input wire logic        motor_turn_ccw
);
	localparam logic [7:0] OFF_LONG = 8'(OFF_FILTER_CYCLES + 10);
	localparam logic [7:0] OFF_MAX  = 8'(OFF_FILTER_CYCLES);
	logic [7:0] off_one, off_two, on_one, on_two;
	logic       long_off, any_off, both_off, any_on;

	assign any_off  = off_one >= OFF_LONG || off_two >= OFF_LONG;
	assign both_off = off_one >= OFF_LONG && off_two >= OFF_LONG;
	assign any_on   = on_one >= 8'h0A || on_two >= 8'h0A;

	// Restart at reset because the filter restarts there too
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{off_one, off_two, on_one, on_two} <= '0;
		end else begin
			off_one <= safety_input_one ? 8'h00 : off_one + 8'(off_one != 8'hFF);
			off_two <= safety_input_two ? 8'h00 : off_two + 8'(off_two != 8'hFF);
			on_one  <= !safety_input_one ? 8'h00 : on_one + 8'(on_one != 8'hFF);
			on_two  <= !safety_input_two ? 8'h00 : on_two + 8'(on_two != 8'hFF);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			long_off <= 1'b0;
		end else if (off_one > OFF_MAX || off_two > OFF_MAX) begin
			long_off <= 1'b1;
		end else if (alarm_output) begin
			// Consumed by this cutoff, so the next entry needs a long off of its own
			long_off <= 1'b0;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	monitor_off_a: assert property (any_on |-> !cutoff_monitor_output)
		else $error("monitor on with an input on");
	monitor_on_a: assert property (both_off |-> cutoff_monitor_output)
		else $error("monitor late with both inputs off");
	cutoff_alarm_a: assert property (any_off |-> alarm_output)
		else $error("no alarm with an input off");
	ready_low_a: assert property (any_off |-> !servo_ready)
		else $error("ready high during cutoff");
	torque_cut_a: assert property ($rose(alarm_output) |-> !torque_enable)
		else $error("torque on at cutoff entry");
	glitch_ignored_a: assert property ($rose(alarm_output) |-> long_off)
		else $error("cutoff after a short off pulse");
	brake_held_a: assert property ((alarm_output && motor_speed == 16'h0000) [*2] |=> brake_hold_output)
		else $error("brake not held at low speed");
	dir_follow_a: assert property ($changed(cmd_forward) |=> $changed(motor_turn_ccw))
		else $error("direction not following command");

	cover property ($rose(alarm_output));
	cover property ($rose(cutoff_monitor_output));
	cover property (alarm_output && $rose(brake_hold_output));
endmodule // cutoff_properties

bind safe_torque_off_monitor cutoff_properties #(.OFF_FILTER_CYCLES(OFF_FILTER_CYCLES)) cutoff_properties_inst (
	.aclk(aclk), .aresetn(aresetn), .safety_input_one(safety_input_one), .safety_input_two(safety_input_two),
	.motor_speed(motor_speed), .cmd_forward(cmd_forward), .cutoff_monitor_output(cutoff_monitor_output),
	.torque_enable(torque_enable), .alarm_output(alarm_output), .brake_hold_output(brake_hold_output),
	.servo_ready(servo_ready), .motor_turn_ccw(motor_turn_ccw));
`default_nettype wire

// file: verification/testbench.sv
// Purpose: Self-checking bench of the torque cutoff block
// Assumes: AXI4-Lite master tasks, pins from the controller model
// Notes:   Filter and millisecond counts shortened to keep the run brief
`timescale 1ns/1ps
`default_nettype none

module testbench;
	localparam int unsigned OFF = 8;
	localparam int unsigned MS  = 4;
	typedef struct packed {
		logic [7:0]  a;
		logic [31:0] d;
		logic [1:0]  r;
	} row_t;
	logic        aclk, aresetn, param_store_clear_n, cmd_forward, want_one, want_two, fault;
	logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic        safety_input_one, safety_input_two, cutoff_monitor_output, torque_enable, alarm_output;
	logic        dynamic_brake_engaged, brake_hold_output, servo_ready, motor_turn_ccw;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	logic [15:0] motor_speed;
	logic [2:0]  control_mode;
	int          bad_count = 0;
	int          n_checks = 0;
	row_t        rows [8] = '{
		'{8'h08, 32'h0000_0000, 2'h0}, '{8'h0C, 32'h0000_0032, 2'h0}, '{8'h10, 32'h0000_001E, 2'h0},
		'{8'h14, 32'h0000_0001, 2'h0}, '{8'h18, 32'h0000_0000, 2'h0}, '{8'h1C, 32'h0000_0001, 2'h0},
		'{8'h04, 32'h0000_00F8, 2'h0}, '{8'h20, 32'h0000_0000, 2'h2}};

	safe_torque_off_monitor #(.OFF_FILTER_CYCLES(OFF), .MS_TICK_CYCLES(MS)) safe_torque_off_monitor_inst (
		.aclk(aclk), .aresetn(aresetn), .param_store_clear_n(param_store_clear_n),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .safety_input_one(safety_input_one),
		.safety_input_two(safety_input_two), .motor_speed(motor_speed), .cmd_forward(cmd_forward),
		.cutoff_monitor_output(cutoff_monitor_output), .torque_enable(torque_enable),
		.alarm_output(alarm_output), .dynamic_brake_engaged(dynamic_brake_engaged),
		.brake_hold_output(brake_hold_output), .servo_ready(servo_ready),
		.motor_turn_ccw(motor_turn_ccw), .control_mode(control_mode));

	safety_controller_model #(.LIMIT(OFF + 12)) safety_controller_model_inst (
		.aclk(aclk), .want_one(want_one), .want_two(want_two), .monitor_in(cutoff_monitor_output),
		.safety_input_one(safety_input_one), .safety_input_two(safety_input_two), .fault(fault));

	initial aclk = 1'b0;
	always #12.5 aclk = ~aclk;

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
	endtask

	task automatic limit(input int n);
		if (n > 60) begin
			bad_count++;
			$display("mismatch at %0t: bus wait ran out", $time);
			end_of_test();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hF;
		{awvalid, wvalid, bready} <= 3'b111;
		do begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			limit(n);
		end while (!bvalid);
		resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'b11;
		do begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
			limit(n);
		end while (!rvalid);
		v = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask

	initial begin
		{aresetn, param_store_clear_n, awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{want_one, want_two, cmd_forward} = 3'b111;
		motor_speed = 16'h0064;
		// Reset loads the filters as on, so two edges are enough
		wt(2);
		aresetn <= 1'b1;
		param_store_clear_n <= 1'b1;
		wt(12);
		foreach (rows[i]) begin
			rd(rows[i].a, d, r);
			chk(d, rows[i].d);
			chk(32'(r), 32'(rows[i].r));
		end
		for (int i = 0; i < 2; i++) begin
			cmd_forward <= 1'(i);
			wt(3);
			chk(32'(motor_turn_ccw), 32'(i));
		end
		want_one <= 1'b0;
		wt(OFF);
		want_one <= 1'b1;
		wt(12);
		chk(32'(alarm_output), 32'h0000_0000);
		wr(8'h00, 32'h0000_0001, r);
		wr(8'h08, 32'h0000_0002, r);
		wr(8'h14, 32'h0000_0000, r);
		wr(8'h18, 32'h0000_0006, r);
		wt(3);
		chk(32'({torque_enable, motor_turn_ccw}), 32'h0000_0003);
		wr(8'h00, 32'h0000_0005, r);
		wt(3);
		chk(32'({motor_turn_ccw, control_mode}), 32'h0000_0000);
		want_one <= 1'b0;
		wt(OFF + 12);
		chk(32'({alarm_output, torque_enable, servo_ready, cutoff_monitor_output,
			dynamic_brake_engaged, brake_hold_output}), 32'h0000_0022);
		wt(MS * 50 + 10);
		chk(32'(brake_hold_output), 32'h0000_0001);
		want_two <= 1'b0;
		motor_speed <= 16'h0000;
		wt(OFF + 12);
		chk(32'(cutoff_monitor_output), 32'h0000_0001);
		wr(8'h00, 32'h0000_0002, r);
		wt(3);
		chk(32'(alarm_output), 32'h0000_0001);
		wr(8'h0C, 32'h0000_0032, r);
		chk(32'(r), 32'h0000_0000);
		{want_one, want_two} <= 2'b11;
		wt(12);
		chk(32'({cutoff_monitor_output, alarm_output}), 32'h0000_0001);
		wr(8'h00, 32'h0000_0002, r);
		wt(3);
		chk(32'({alarm_output, servo_ready, dynamic_brake_engaged}), 32'h0000_0002);
		wr(8'h00, 32'h0000_0001, r);
		want_one <= 1'b0;
		wt(OFF + 12);
		chk(32'(brake_hold_output), 32'h0000_0001);
		wr(8'h00, 32'h0000_0002, r);
		rd(8'h04, d, r);
		chk(32'(d[31:16]), 32'h0000_0990);
		want_one <= 1'b1;
		wt(12);
		wr(8'h00, 32'h0000_0002, r);
		wt(3);
		chk(32'(alarm_output), 32'h0000_0001);
		aresetn <= 1'b0;
		wt(4);
		aresetn <= 1'b1;
		wt(12);
		chk(32'({alarm_output, motor_turn_ccw, control_mode}), 32'h0000_0006);
		chk(32'(fault), 32'h0000_0000);
		end_of_test();
	end
endmodule // testbench
`default_nettype wire
